// file: fplb_pkg.sv
// Purpose: Constants and types shared by the flash prefetch line buffer.
// Assumes: 40 MHz system clock, 128-bit flash array path, 32-bit requester path.
// Notes: Error correction is a single-error-correcting Hamming code over each 32-bit word.
package fplb_pkg;
    localparam int ADDR_W = 24;
    localparam int WORD_W = 32;
    localparam int LINE_W = 128;
    localparam int ECC_W = 7;
    localparam int WORDS_PER_LINE = 4;
    localparam int OFF_W = 4;
    localparam int TAG_W = ADDR_W - OFF_W;
    localparam int NUM_LINES = 4;
    localparam logic [1:0] LINE_INSTR = 2'h0;
    localparam logic [1:0] LINE_DATA = 2'h1;
    localparam logic [1:0] LINE_PER0 = 2'h2;
    localparam logic [1:0] LINE_PER1 = 2'h3;
    localparam logic [1:0] SRC_INSTR = 2'h0;
    localparam logic [1:0] SRC_DATA = 2'h1;
    localparam logic [1:0] SRC_PERIPH = 2'h2;
    localparam int FLASH_ACCESS_NS = 50;
    localparam int CLK_PERIOD_NS = 25;
    localparam int WAIT_CYCLES = (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WAIT_LAST = 4'(WAIT_CYCLES - 1);
    typedef enum logic [1:0] {FPLB_IDLE, FPLB_WAIT, FPLB_FILL} fplb_state_e;
endpackage : fplb_pkg

// file: fplb_ecc_word.sv
// Purpose: Corrects one 32-bit word read from the flash array using its check bits.
// Assumes: Check bits are Hamming positions 1,2,4,8,16,32 plus an overall parity bit.
// Notes: Single errors are corrected, double errors are flagged and passed uncorrected.
`timescale 1ns/1ps
module fplb_ecc_word (
    input wire logic [31:0] data_in, // Raw data word.
    input wire logic [6:0] check_in, // Stored check bits.
    output logic [31:0] data_out, // Corrected data word.
    output logic single_err, // Corrected single-bit error.
    output logic double_err // Uncorrectable error.
);
    logic [38:1] code;
    logic [5:0] syn;
    logic par;
    logic [38:1] fixed;
    int k;
    always_comb begin
        code = '0;
        k = 0;
        for (int p = 1; p <= 38; p++) begin
            if ((p & (p - 1)) == 0) begin
                code[p] = 1'b0;
            end else begin
                code[p] = data_in[k];
                k = k + 1;
            end
        end
        for (int b = 0; b < 6; b++) begin
            code[1 << b] = check_in[b];
        end
        syn = '0;
        for (int p = 1; p <= 38; p++) begin
            if (code[p]) begin
                syn = syn ^ 6'(p);
            end
        end
        par = ^code ^ check_in[6];
        fixed = code;
        if (par && syn != 6'h00 && syn <= 6'h26) begin
            fixed[syn] = ~code[syn];
        end
        data_out = '0;
        k = 0;
        for (int p = 1; p <= 38; p++) begin
            if ((p & (p - 1)) != 0) begin
                data_out[k] = fixed[p];
                k = k + 1;
            end
        end
        single_err = par;
        double_err = !par && syn != 6'h00;
    end
endmodule : fplb_ecc_word

// file: fplb_top.sv
// Purpose: Four-line fully associative prefetch buffer in front of the program flash array.
// Assumes: One refill runs at a time; hits of all requesters are served in parallel; for misses instruction fetch has priority, then CPU data,
// Assumes: then peripheral data. Requests hold steady until acknowledged.
// Notes: A hit answers the cycle after the request; a miss refills the owner's line after wait states.
`timescale 1ns/1ps
module fplb_top (
    input wire logic CLK, // System clock.
    input wire logic RST_B, // Asynchronous reset, active low.
    input wire logic CE, // Clock enable, freezes state when low.
    input wire logic PREFETCH_EN, // Enables predictive instruction prefetch.
    input wire logic IREQ, // Instruction fetch request.
    input wire logic [23:0] IADDR, // Instruction byte address.
    output logic IACK, // Instruction word valid.
    output logic [31:0] IDATA, // Instruction word.
    input wire logic DREQ, // CPU data read request.
    input wire logic [23:0] DADDR, // CPU data byte address.
    output logic DACK, // CPU data valid.
    output logic [31:0] DDATA, // CPU data word.
    input wire logic PREQ, // Peripheral read request.
    input wire logic [23:0] PADDR, // Peripheral byte address.
    output logic PACK, // Peripheral data valid.
    output logic [31:0] PDATA, // Peripheral data word.
    output logic FLASH_RD, // Wide read strobe to the flash array.
    output logic [19:0] FLASH_ADDR, // Line address to the flash array.
    input wire logic [127:0] FLASH_DATA, // Wide read data from the flash array.
    input wire logic [27:0] FLASH_ECC, // Check bits, seven per word.
    output logic ECC_SINGLE, // Pulse: corrected error on refill.
    output logic ECC_DOUBLE // Pulse: uncorrectable error on refill.
);
    logic [fplb_pkg::TAG_W-1:0] tag [fplb_pkg::NUM_LINES];
    logic [fplb_pkg::LINE_W-1:0] line [fplb_pkg::NUM_LINES];
    logic [fplb_pkg::NUM_LINES-1:0] valid;
    logic [fplb_pkg::NUM_LINES-1:0] hit_i, hit_d, hit_p;
    logic [fplb_pkg::NUM_LINES-1:0] next_valid;
    logic [fplb_pkg::TAG_W-1:0] next_tag [fplb_pkg::NUM_LINES];
    logic [fplb_pkg::LINE_W-1:0] next_line [fplb_pkg::NUM_LINES];
    fplb_pkg::fplb_state_e state, next_state;
    logic [3:0] wait_cnt, next_wait_cnt;
    logic [1:0] fill_line, next_fill_line;
    logic [fplb_pkg::TAG_W-1:0] fill_tag, next_fill_tag;
    logic pf_fill, next_pf_fill;
    logic pper, next_pper;
    logic [fplb_pkg::LINE_W-1:0] fixed_line;
    logic [3:0] sgl, dbl;
    logic [31:0] next_idata, next_ddata, next_pdata;
    logic next_iack, next_dack, next_pack;
    logic iack_r, dack_r, pack_r;
    logic next_flash_rd, next_ecc_s, next_ecc_d;
    logic [19:0] next_flash_addr;
    logic i_hit, d_hit, p_hit;
    logic [1:0] p_line;

    // One corrector per word of the wide read.
    genvar g;
    generate
        for (g = 0; g < fplb_pkg::WORDS_PER_LINE; g++) begin : g_ecc
            fplb_ecc_word u_ecc (
                .data_in(FLASH_DATA[g*32 +: 32]),
                .check_in(FLASH_ECC[g*7 +: 7]),
                .data_out(fixed_line[g*32 +: 32]),
                .single_err(sgl[g]),
                .double_err(dbl[g])
            );
        end
    endgenerate

    function automatic logic [31:0] pick(input logic [127:0] l, input logic [23:0] a);
        pick = l[a[3:2]*32 +: 32];
    endfunction : pick

    always_comb begin
        for (int i = 0; i < fplb_pkg::NUM_LINES; i++) begin
            hit_i[i] = valid[i] && tag[i] == IADDR[23:4];
            hit_d[i] = valid[i] && tag[i] == DADDR[23:4];
            hit_p[i] = valid[i] && tag[i] == PADDR[23:4];
        end
    end

    // Any line may answer any requester; refills go only to the requester's own line.
    assign i_hit = |hit_i;
    assign d_hit = |hit_d;
    assign p_hit = |hit_p;
    assign p_line = pper ? fplb_pkg::LINE_PER1 : fplb_pkg::LINE_PER0;

    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_fill_line = fill_line;
        next_fill_tag = fill_tag;
        next_pf_fill = pf_fill;
        next_pper = pper;
        next_valid = valid;
        next_tag = tag;
        next_line = line;
        next_flash_rd = 1'b0;
        next_flash_addr = FLASH_ADDR;
        next_ecc_s = 1'b0;
        next_ecc_d = 1'b0;
        next_iack = 1'b0;
        next_dack = 1'b0;
        next_pack = 1'b0;
        next_idata = IDATA;
        next_ddata = DDATA;
        next_pdata = PDATA;
        for (int i = 0; i < fplb_pkg::NUM_LINES; i++) begin
            if (hit_i[i]) next_idata = pick(line[i], IADDR);
            if (hit_d[i]) next_ddata = pick(line[i], DADDR);
            if (hit_p[i]) next_pdata = pick(line[i], PADDR);
        end
        // The ack register blocks a second answer to a request that is still held.
        next_iack = IREQ && i_hit && !iack_r;
        next_dack = DREQ && d_hit && !dack_r;
        next_pack = PREQ && p_hit && !pack_r;
        unique case (state)
            fplb_pkg::FPLB_IDLE: begin
                if (IREQ && !i_hit) begin
                    next_fill_line = fplb_pkg::LINE_INSTR;
                    next_fill_tag = IADDR[23:4];
                    next_pf_fill = 1'b0;
                    next_state = fplb_pkg::FPLB_WAIT;
                end else if (DREQ && !d_hit) begin
                    next_fill_line = fplb_pkg::LINE_DATA;
                    next_fill_tag = DADDR[23:4];
                    next_pf_fill = 1'b0;
                    next_state = fplb_pkg::FPLB_WAIT;
                end else if (PREQ && !p_hit) begin
                    next_fill_line = p_line;
                    next_fill_tag = PADDR[23:4];
                    next_pf_fill = 1'b0;
                    next_pper = ~pper;
                    next_state = fplb_pkg::FPLB_WAIT;
                end else if (PREFETCH_EN && IREQ && IADDR[3:2] == 2'h3 && valid[0]
                             && tag[0] == IADDR[23:4]) begin
                    // Fetch the next sequential line while the last word is being used.
                    next_fill_line = fplb_pkg::LINE_INSTR;
                    next_fill_tag = 20'(IADDR[23:4] + 20'h1);
                    next_pf_fill = 1'b1;
                    next_state = fplb_pkg::FPLB_WAIT;
                end
                if (next_state == fplb_pkg::FPLB_WAIT) begin
                    next_flash_rd = 1'b1;
                    next_flash_addr = next_fill_tag;
                    next_wait_cnt = '0;
                end
            end
            fplb_pkg::FPLB_WAIT: begin
                // Count wait states so that the array's access time is met.
                if (wait_cnt == fplb_pkg::WAIT_LAST) begin
                    next_state = fplb_pkg::FPLB_FILL;
                end else begin
                    next_wait_cnt = 4'(wait_cnt + 4'h1);
                end
            end
            fplb_pkg::FPLB_FILL: begin
                // The wide read is valid now; a prefetch switched off meanwhile is dropped.
                if (!pf_fill || PREFETCH_EN) begin
                    next_line[fill_line] = fixed_line;
                    next_tag[fill_line] = fill_tag;
                    next_valid[fill_line] = 1'b1;
                end
                next_ecc_s = |sgl;
                next_ecc_d = |dbl;
                next_state = fplb_pkg::FPLB_IDLE;
            end
            default: begin
                next_state = fplb_pkg::FPLB_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= fplb_pkg::FPLB_IDLE;
            wait_cnt <= '0;
            fill_line <= '0;
            fill_tag <= '0;
            pf_fill <= 1'b0;
            pper <= 1'b0;
            valid <= '0;
            for (int i = 0; i < fplb_pkg::NUM_LINES; i++) begin
                tag[i] <= '0;
                line[i] <= '0;
            end
            FLASH_RD <= 1'b0;
            FLASH_ADDR <= '0;
            ECC_SINGLE <= 1'b0;
            ECC_DOUBLE <= 1'b0;
            iack_r <= 1'b0;
            dack_r <= 1'b0;
            pack_r <= 1'b0;
            IDATA <= '0;
            DDATA <= '0;
            PDATA <= '0;
        end else if (CE) begin
            // A low clock enable holds every register, outputs included.
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            fill_line <= next_fill_line;
            fill_tag <= next_fill_tag;
            pf_fill <= next_pf_fill;
            pper <= next_pper;
            valid <= next_valid;
            tag <= next_tag;
            line <= next_line;
            FLASH_RD <= next_flash_rd;
            FLASH_ADDR <= next_flash_addr;
            ECC_SINGLE <= next_ecc_s;
            ECC_DOUBLE <= next_ecc_d;
            iack_r <= next_iack;
            dack_r <= next_dack;
            pack_r <= next_pack;
            IDATA <= next_idata;
            DDATA <= next_ddata;
            PDATA <= next_pdata;
        end
    end

    assign IACK = iack_r;
    assign DACK = dack_r;
    assign PACK = pack_r;
endmodule : fplb_top

// file: fplb_top_asserts.sv
// Purpose: Port-level assertions for the flash prefetch line buffer.
// Assumes: Requesters hold a request until it is acknowledged.
// Notes: Bound into every instance of the top module.
`timescale 1ns/1ps
module fplb_top_asserts (
    input wire logic CLK, // Clock.
    input wire logic RST_B, // Reset.
    input wire logic IREQ, // Fetch request.
    input wire logic IACK, // Fetch ack.
    input wire logic [31:0] IDATA, // Fetch word.
    input wire logic DREQ, // Data request.
    input wire logic DACK, // Data ack.
    input wire logic PREQ, // Peripheral request.
    input wire logic PACK, // Peripheral ack.
    input wire logic [31:0] PDATA, // Peripheral word.
    input wire logic FLASH_RD, // Wide read strobe.
    input wire logic [19:0] FLASH_ADDR, // Line address.
    input wire logic ECC_SINGLE, // Corrected error.
    input wire logic ECC_DOUBLE // Uncorrectable error.
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    AST_RD_SPACING: assert property (FLASH_RD |=> !FLASH_RD [*3]) else $error("bad spacing");
    AST_ADDR_HOLD: assert property (FLASH_RD |=> $stable(FLASH_ADDR) [*3]) else $error("addr");
    AST_ECC_CAUSE: assert property ((ECC_SINGLE || ECC_DOUBLE) |->
        ($past(FLASH_RD, 3) || $past(FLASH_RD, 4))) else $error("stray ecc pulse");
    AST_ECC_EXCL: assert property (ECC_DOUBLE |-> !ECC_SINGLE) else $error("ecc both");
    AST_IDATA_HOLD: assert property ($changed(IDATA) |-> IACK) else $error("idata moved");
    AST_PDATA_HOLD: assert property ($changed(PDATA) |-> PACK) else $error("pdata moved");
    AST_ACK_CAUSE: assert property (IACK |-> $past(IREQ)) else $error("ack unasked");
    AST_I_ANSWER: assert property (IREQ && !IACK |-> ##[1:12] IACK) else $error("i late");
    AST_D_ANSWER: assert property (DREQ && !DACK |-> ##[1:16] DACK) else $error("d late");
    AST_P_ANSWER: assert property (PREQ && !PACK |-> ##[1:20] PACK) else $error("p late");
endmodule : fplb_top_asserts
bind fplb_top fplb_top_asserts fplb_top_asserts_inst (.*);

// file: fplb_flash_model.sv
// Purpose: Behavioural program flash array behind the line buffer.
// Assumes: One wide read at a time.
// Notes: Outside the wait window the data lines show the inverted line.
`timescale 1ns/1ps
module fplb_flash_model (
    input wire logic clk, // Clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic rd, // Wide read strobe.
    input wire logic [19:0] addr, // Line address.
    input wire logic [1:0] err_mode, // 1 flips one bit, 2 flips two.
    output logic [127:0] data, // Line data.
    output logic [27:0] ecc // Check bits.
);
    logic [2:0] cnt;
    logic [127:0] lv;
    logic [27:0] ev;
    logic ok;
    function automatic logic [6:0] enc(input logic [31:0] d);
        logic [38:1] c;
        logic [6:0] k;
        int j;
        c = '0;
        k = '0;
        j = 0;
        for (int p = 1; p <= 38; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[j];
                j++;
            end
            for (int b = 0; b < 6; b++) k[b] ^= c[p] & p[b];
        end
        k[6] = ^{d, k[5:0]};
        return k;
    endfunction : enc
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) cnt <= 3'h0;
        else if (rd) cnt <= 3'h1;
        else if (cnt != 3'h0 && cnt < 3'h5) cnt <= cnt + 3'h1;
        else cnt <= 3'h0;
    end
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            lv[n*32 +: 32] = {8'ha5, addr, 2'h0, 2'(n)};
            ev[n*7 +: 7] = enc(lv[n*32 +: 32]);
        end
        lv[5] ^= (err_mode != 2'h0);
        lv[6] ^= (err_mode == 2'h2);
        ok = cnt >= 3'(fplb_pkg::WAIT_CYCLES) && cnt <= 3'(fplb_pkg::WAIT_CYCLES + 2);
        data = ok ? lv : ~lv;
        ecc = ok ? ev : ~ev;
    end
endmodule : fplb_flash_model

// file: flash_prefetch_line_buffer_tb.sv
// Purpose: Self-checking bench for the flash prefetch line buffer.
// Assumes: A behavioural flash model answers each wide read.
// Notes: Requests rise at an edge and drop at the edge that sees the ack.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module flash_prefetch_line_buffer_tb;
    logic CLK = 1'b0, RST_B = 1'b0, CE = 1'b1, PREFETCH_EN = 1'b0;
    logic IREQ = 1'b0, DREQ = 1'b0, PREQ = 1'b0;
    logic [23:0] IADDR = 24'h0, DADDR = 24'h0, PADDR = 24'h0;
    logic IACK, DACK, PACK, FLASH_RD, ECC_SINGLE, ECC_DOUBLE;
    logic [31:0] IDATA, DDATA, PDATA;
    logic [19:0] FLASH_ADDR;
    logic [127:0] FLASH_DATA;
    logic [27:0] FLASH_ECC;
    logic [1:0] err_mode = 2'h0;
    int error_cnt = 0, check_count = 0, rd_cnt = 0, sgl = 0, dbl = 0;
    fplb_top fplb_top_inst (.*);
    fplb_flash_model fplb_flash_model_inst (.clk(CLK), .rst_b(RST_B), .rd(FLASH_RD),
        .addr(FLASH_ADDR), .err_mode(err_mode), .data(FLASH_DATA), .ecc(FLASH_ECC));
    always #12.5 CLK = ~CLK;
    always @(negedge CLK) begin
        rd_cnt += int'(FLASH_RD === 1'b1);
        sgl += int'(ECC_SINGLE === 1'b1);
        dbl += int'(ECC_DOUBLE === 1'b1);
    end
    function automatic logic [31:0] word(input logic [23:0] a);
        return {8'ha5, a[23:4], 2'h0, a[3:2]};
    endfunction : word
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic rd(input int p, input logic [23:0] a, output logic [31:0] d, output int n);
        logic ack;
        @(posedge CLK);
        case (p)
            0: begin IREQ <= 1'b1; IADDR <= a; end
            1: begin DREQ <= 1'b1; DADDR <= a; end
            default: begin PREQ <= 1'b1; PADDR <= a; end
        endcase
        for (n = 1; n <= 20; n++) begin
            @(posedge CLK);
            ack = (p == 0) ? IACK : (p == 1) ? DACK : PACK;
            d = (p == 0) ? IDATA : (p == 1) ? DDATA : PDATA;
            if (ack === 1'b1) break;
        end
        IREQ <= 1'b0;
        DREQ <= 1'b0;
        PREQ <= 1'b0;
        if (n > 20) begin
            error_cnt++;
            $display("unexpected at %0t: no ack", $time);
            end_sim();
        end
    endtask : rd
    task automatic rd_chk(input int p, input logic [23:0] a, input bit hit);
        logic [31:0] d;
        int n, c;
        c = rd_cnt;
        rd(p, a, d, n);
        `CHK(d, word(a))
        `CHK(n, hit ? 2 : 4 + fplb_pkg::WAIT_CYCLES)
        `CHK(rd_cnt - c, int'(!hit))
    endtask : rd_chk
    task automatic t_fill;
        rd_chk(0, 24'h000100, 1'b0);
        rd_chk(0, 24'h000104, 1'b1);
        rd_chk(0, 24'h00010c, 1'b1);
        $display("test fill done");
    endtask : t_fill
    task automatic t_owners;
        rd_chk(1, 24'h000200, 1'b0);
        rd_chk(2, 24'h000300, 1'b0);
        rd_chk(2, 24'h000400, 1'b0);
        rd_chk(0, 24'h000500, 1'b0);
        rd_chk(1, 24'h000208, 1'b1);
        rd_chk(2, 24'h000304, 1'b1);
        rd_chk(2, 24'h000408, 1'b1);
        rd_chk(0, 24'h000504, 1'b1);
        rd_chk(1, 24'h00030c, 1'b1);
        $display("test owners done");
    endtask : t_owners
    task automatic t_prefetch;
        logic [31:0] d;
        logic [23:0] a;
        int n, c;
        for (int en = 0; en < 2; en++) begin
            a = en[0] ? 24'h001000 : 24'h001100;
            PREFETCH_EN <= en[0];
            rd_chk(0, a | 24'h8, 1'b0);
            c = rd_cnt;
            rd(0, a | 24'hc, d, n);
            `CHK(n, 2)
            repeat (8) @(posedge CLK);
            `CHK(rd_cnt - c, en)
            rd_chk(0, a + 24'h10, en[0]);
        end
        PREFETCH_EN <= 1'b0;
        $display("test prefetch done");
    endtask : t_prefetch
    task automatic t_ecc;
        logic [31:0] d;
        logic [23:0] a;
        int n, s, t;
        for (int m = 1; m < 3; m++) begin
            a = 24'h002000 + 24'(m * 16);
            err_mode <= 2'(m);
            s = sgl;
            t = dbl;
            rd(0, a, d, n);
            repeat (2) @(posedge CLK);
            `CHK(d, word(a) ^ ((m == 2) ? 32'h60 : 32'h0))
            `CHK(sgl - s, int'(m == 1))
            `CHK(dbl - t, int'(m == 2))
        end
        err_mode <= 2'h0;
        $display("test ecc done");
    endtask : t_ecc
    task automatic t_reset;
        RST_B <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        rd_chk(0, 24'h000104, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_freeze;
        int c;
        @(posedge CLK);
        c = rd_cnt;
        CE <= 1'b0;
        IREQ <= 1'b1;
        IADDR <= 24'h000108;
        repeat (3) @(posedge CLK);
        `CHK(IACK, 1'b0)
        CE <= 1'b1;
        repeat (2) @(posedge CLK);
        `CHK(IACK, 1'b1)
        `CHK(IDATA, word(24'h000108))
        IREQ <= 1'b0;
        `CHK(rd_cnt - c, 0)
        $display("test freeze done");
    endtask : t_freeze
    initial begin
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
        t_fill();
        t_owners();
        t_prefetch();
        t_ecc();
        t_reset();
        t_freeze();
        end_sim();
    end
endmodule : flash_prefetch_line_buffer_tb
